// ==== e1fg_chk_sva.sv ====
`timescale 1ns/1ns
`include "e1fg_map.svh"
// ==========================================================
// Port checks; shadows of control state track completed writes
module e1fg_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Stream and interrupt
    input wire logic        in_valid,
    input wire logic        in_bit,
    input wire logic        out_valid,
    input wire logic        out_bit,
    input wire logic        irq_n
);
    localparam logic [6:0] FAS  = `E1FG_FAS_WORD;
    localparam logic [5:0] MFAS = `E1FG_MFAS_WORD;
    logic        wr;
    logic        fr_on;
    logic [6:0]  ctrl_q;
    logic [4:0]  flen_q;
    logic        inv_q;
    logic [11:0] pos_q;
    logic [11:0] opos_q;

    // Write strobe and frame-overlay mode
    assign wr    = psel && penable && pready && pwrite;
    assign fr_on = !ctrl_q[0] && !(ctrl_q[1] && ctrl_q[2]);

    // Shadows; inversions disable the pattern checks for good
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 7'h01;
            flen_q <= 5'h00;
            inv_q  <= 1'b0;
            pos_q  <= 12'h000;
            opos_q <= 12'h000;
        end else begin
            if (wr && paddr == `E1FG_OFS_CTRL) ctrl_q <= pwdata[6:0];
            if (wr && paddr == `E1FG_OFS_FLAGEN) flen_q <= pwdata[4:0];
            if (wr && paddr == `E1FG_OFS_INV && pwdata[5:0] != 6'h00) inv_q <= 1'b1;
            if (in_valid) pos_q <= pos_q + 12'h001;
            if (in_valid) opos_q <= pos_q;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_unmapped_err: assert property (psel && !penable && (paddr > 8'h1c || paddr[1:0] != 2'h0)
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    a_out_lag: assert property (in_valid |=> out_valid)
        else $error("output strobe missing");
    a_idle_low: assert property (!out_valid |-> !out_bit)
        else $error("data while idle");
    a_pass_thru: assert property (ctrl_q[0] && in_valid && !wr |=> out_bit == $past(in_bit))
        else $error("payload altered while framing off");
    a_fas_even: assert property (out_valid && fr_on && !inv_q && !opos_q[8] && opos_q[7:3] == 5'h0
        && opos_q[2:0] != 3'h0 |-> out_bit == FAS[3'd7 - opos_q[2:0]])
        else $error("alignment word wrong");
    a_nfas_odd: assert property (out_valid && fr_on && !inv_q && opos_q[8] && opos_q[7:0] == 8'h01
        |-> out_bit)
        else $error("odd frame marker wrong");
    a_mfas_word: assert property (out_valid && fr_on && ctrl_q[1] && !inv_q && opos_q[8]
        && opos_q[11:8] < 4'd12 && opos_q[7:0] == 8'h00
        |-> out_bit == MFAS[3'd5 - opos_q[11:9]])
        else $error("multiframe word wrong");
    a_irq_gated: assert property ((flen_q == 5'h00)[*3] |-> irq_n)
        else $error("interrupt while all disabled");
    a_irq_raise: assert property (in_valid && !ctrl_q[0] && pos_q[7:0] == 8'h00 && flen_q[1]
        |-> ##[1:4] !irq_n)
        else $error("frame interrupt missing");

    // Main scenarios reached
    c_inv_req: cover property (wr && paddr == `E1FG_OFS_INV);
    c_mf_start: cover property (out_valid && fr_on && opos_q == 12'h000);
    c_refused: cover property (pready && pslverr);
endmodule : e1fg_chk

bind e1fg_top e1fg_chk e1fg_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_bit, .out_valid, .out_bit, .irq_n);

// ==== e1fg_crc.sv ====
`timescale 1ns/1ns
// ==========================================================
// Serial CRC, MSB-first shift with feedback polynomial
module e1fg_crc #(
    parameter int           WIDTH = 4,
    parameter logic [WIDTH-1:0] POLY = 4'h3
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Data
    input  wire logic             step,
    input  wire logic             restart,
    input  wire logic             din,
    output logic      [WIDTH-1:0] crc_next
);
    logic [WIDTH-1:0] crc_q;
    logic             fb;

    // Feedback term and next remainder
    assign fb       = crc_q[WIDTH-1] ^ din;
    assign crc_next = {crc_q[WIDTH-2:0], 1'b0} ^ (fb ? POLY : '0);

    // Restart clears in the same step as the result is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_q <= '0;
        end else if (step) begin
            crc_q <= restart ? '0 : crc_next;
        end
    end
endmodule : e1fg_crc

// ==== e1fg_map.svh ====
// ==========================================================
// How it works
// - framing disable, CRC enable, modified CRC, signalling enable pick the frame type
// - alignment word in TS0 bits 2-8 of even frames, bit 2 one in odd
// - each request inverts one alignment bit, one alignment word or one marker bit
// - basic frames send upper/lower international value in bit 1 when not disabled
// - manual remote alarm sends a one in the A bit
// - automatic remote alarm follows receive conditions chosen by criterion select
// - basic frames send first codeword bit of each enabled national bit
// - CRC multiframe alignment word in bit 1 of first six odd frames
// - CRC of previous sub-multiframe goes into bit 1 of even frames
// - each request inverts one CRC alignment word or one set of CRC bits
// - reporting on and alignment held: one zero per receive CRC error
// - international values fill E bits when alignment lost or reporting off
// - reporting off with international disable set leaves E bits untouched
// - CRC multiframes send each national bit's four codeword bits in successive odd frames
// - signalling multiframes place four zeros in TS16 bits 1-4 of frame 0
// - each request inverts one signalling alignment word
// - extra bits fill TS16 bits 5, 7 and 8 of frame 0 unless disabled
// - signalling alarm value goes into TS16 bit 6 of frame 0
// - TS16 all-zero or all-one overwrite, zeros win
// - modified CRC mode changes only national and CRC bits
// - framing disabled passes payload through untouched
// - flags set at first bit of each unit, enabled flags drive interrupt low
`ifndef E1FG_MAP_SVH
`define E1FG_MAP_SVH

// ==========================================================
// Register offsets
`define E1FG_OFS_CTRL   8'h00
`define E1FG_OFS_INV    8'h04
`define E1FG_OFS_MAINT  8'h08
`define E1FG_OFS_NATEN  8'h0c
`define E1FG_OFS_CODE   8'h10
`define E1FG_OFS_EXTRA  8'h14
`define E1FG_OFS_FLAG   8'h18
`define E1FG_OFS_FLAGEN 8'h1c

// ==========================================================
// Control field positions
`define E1FG_CTRL_FRAMING_DISABLE   0
`define E1FG_CTRL_CRC    1
`define E1FG_CTRL_MOD    2
`define E1FG_CTRL_SIG    3
`define E1FG_CTRL_INTL_BIT_INSERT_DISABLE  4
`define E1FG_CTRL_FEDIS  5
`define E1FG_CTRL_EXTRA_BITS_DISABLE   6
`define E1FG_MNT_RAIM    2
`define E1FG_MNT_RAIA    3
`define E1FG_MNT_CRIT    4
`define E1FG_MNT_MFAL    5
`define E1FG_MNT_ZERO    6
`define E1FG_MNT_ONE     7

// ==========================================================
// Reset values and patterns
`define E1FG_CTRL_RST  7'h01
`define E1FG_MAINT_RST 8'h03
`define E1FG_FAS_WORD  7'h1b
`define E1FG_MFAS_WORD 6'h0b
`define E1FG_CRC_POLY  4'h3

`endif

// ==== e1fg_payload_src.sv ====
`timescale 1ns/1ns
// ==========================================================
// Upstream payload source, stalls every other cycle on gap
module e1fg_payload_src (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench control
    input  wire logic        go,
    input  wire logic        gap,
    input  wire logic [15:0] nbits,
    // Payload towards the generator
    output logic             in_valid,
    output logic             in_bit,
    output logic             busy
);
    logic [15:0] left_q;
    logic [11:0] lfsr_q;
    logic        ph_q;

    // Bit budget, pattern and stall phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 16'h0000;
            lfsr_q <= 12'h5a3;
            ph_q   <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
            if (go) left_q <= nbits;
            else if (in_valid) left_q <= left_q - 16'h0001;
            if (in_valid) lfsr_q <= {lfsr_q[10:0], lfsr_q[11] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0]};
        end
    end

    // Idle data toggles, so a stale bit never passes for payload
    assign busy     = (left_q != 16'h0000);
    assign in_valid = busy && (!gap || ph_q);
    assign in_bit   = in_valid ? lfsr_q[11] : ph_q;
endmodule : e1fg_payload_src

// ==== e1fg_pkg.sv ====
package e1fg_pkg;
    // Invert request slots
    typedef enum logic [2:0] {
        E1FG_INV_FAS_BIT  = 3'h0,
        E1FG_INV_FAS_WORD = 3'h1,
        E1FG_INV_NFAS     = 3'h2,
        E1FG_INV_MFAS     = 3'h3,
        E1FG_INV_SIG      = 3'h4,
        E1FG_INV_CRC      = 3'h5
    } e1fg_inv_t;

    // Indication flag slots
    typedef enum logic [2:0] {
        E1FG_FLG_ALIGN = 3'h0,
        E1FG_FLG_BASIC = 3'h1,
        E1FG_FLG_CRCMF = 3'h2,
        E1FG_FLG_SMF   = 3'h3,
        E1FG_FLG_SIGMF = 3'h4
    } e1fg_flag_t;

    typedef logic [5:0] e1fg_invvec_t;
    typedef logic [4:0] e1fg_flagvec_t;
endpackage : e1fg_pkg

// ==== e1fg_tb.sv ====
`timescale 1ns/1ns
`include "e1fg_map.svh"
// ==========================================================
// Bench: APB set-up, whole multiframes, capture and compare
module e1fg_tb;
    localparam logic [6:0] FAS  = `E1FG_FAS_WORD;
    localparam logic [5:0] MFAS = `E1FG_MFAS_WORD;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, mnt;
    logic [31:0] pwdata = 32'h0, prdata, rd, code;
    logic        pready, pslverr, in_valid, in_bit, out_valid, out_bit, irq_n, busy, err;
    logic        mf_lost = 1, go = 0, gap = 0, irq_low = 0;
    logic [15:0] nbits = 16'h0;
    logic [6:0]  ctrl;
    logic [4:0]  nat;
    logic [2:0]  ex;
    logic        icap [8192];
    logic        ocap [8192];
    int          ic, oc, miscompares, n_checks, cycles;
    int          nbad [5] = '{1, 7, 1, 6, 4};
    logic [7:0]  mt [3] = '{8'h29, 8'ha5, 8'he5};

    always #5 pclk = ~pclk;

    e1fg_top e1fg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_bit(in_bit), .rx_frame_lost(mf_lost),
        .rx_alt_alarm(1'b0), .crc_mf_alignment_lost(mf_lost), .rx_crc_error(1'b0),
        .rx_crc_smf(1'b0), .out_valid(out_valid), .out_bit(out_bit), .irq_n(irq_n));
    e1fg_payload_src e1fg_payload_src_inst (.pclk(pclk), .presetn(presetn), .go(go), .gap(gap),
        .nbits(nbits), .in_valid(in_valid), .in_bit(in_bit), .busy(busy));

    // Capture both sides; watchdog sized for about 80k cycles of work
    always @(posedge pclk) begin
        cycles++;
        if (in_valid) icap[ic % 8192] = in_bit;
        if (in_valid) ic++;
        if (out_valid) ocap[oc % 8192] = out_bit;
        if (out_valid) oc++;
        if (!irq_n) irq_low = 1;
        if (cycles == 95000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is sampled
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task cfg;
        apb(1, `E1FG_OFS_CTRL, {25'h0, ctrl});
        apb(1, `E1FG_OFS_MAINT, {24'h0, mnt});
        apb(1, `E1FG_OFS_EXTRA, {29'h0, ex});
        apb(1, `E1FG_OFS_NATEN, {27'h0, nat});
        apb(1, `E1FG_OFS_CODE, code);
    endtask : cfg

    // Stream n bits; whole multiframes keep the positions aligned
    task run(input int n, input logic g);
        ic = 0;
        oc = 0;
        @(posedge pclk);
        go <= 1;
        nbits <= n[15:0];
        gap <= g;
        @(posedge pclk);
        go <= 0;
        @(posedge pclk);
        while (busy) @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask : run

    // Expected bit at multiframe position p, -1 where not predicted
    function automatic int ebit(int p, logic i);
        logic [3:0] f;
        logic [4:0] t;
        logic [2:0] b;
        logic [7:0] s;
        logic       crc;
        f = p[11:8];
        t = p[7:3];
        b = p[2:0];
        s = {4'h0, ex[0], mnt[5], ex[1], ex[2]};
        crc = ctrl[1];
        if (ctrl[0]) return i;
        if (ctrl[3] && t == 5'd16) return mnt[6] ? 0 : (mnt[7] ? 1 : (f == 0 ? s[7 - b] : i));
        if (t != 0) return i;
        if (crc && ctrl[2] && !(f[0] && b > 2)) return (!f[0] && b == 0) ? -1 : i;
        if (!f[0]) return b != 0 ? FAS[7 - b] : (crc ? -1 : (ctrl[4] ? i : mnt[1]));
        if (b == 1) return 1;
        if (b == 2) return mnt[2] | (mnt[3] & !mnt[4]);
        if (b > 2) return nat[b - 3] ? code[4 * (b - 3) + (crc ? f[2:1] : 0)] : i;
        if (!crc) return ctrl[4] ? i : mnt[0];
        return f < 12 ? MFAS[5 - f[3:1]] : (f == 13 ? mnt[1] : mnt[0]);
    endfunction : ebit

    task cmp(input int n, input int want);
        int bad;
        int e;
        bad = 0;
        for (int p = 0; p < n; p++) begin
            e = ebit(p, icap[p]);
            if (e >= 0 && ocap[p] !== e[0]) bad++;
        end
        chk(bad, want);
    endtask : cmp

    // CRC over the first sub-multiframe, its bit slots counted as zero
    task crc_chk;
        logic [3:0] c;
        logic       d;
        c = 4'h0;
        for (int p = 0; p < 2048; p++) begin
            d = (!p[8] && p[7:0] == 0) ? 1'b0 : ocap[p];
            c = {c[2:0], 1'b0} ^ ((c[3] ^ d) ? `E1FG_CRC_POLY : 4'h0);
        end
        chk({ocap[2048], ocap[2560], ocap[3072], ocap[3584]}, c);
    endtask : crc_chk

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, `E1FG_OFS_CTRL, 0);
        chk(rd, 32'h1);
        apb(0, `E1FG_OFS_MAINT, 0);
        chk(rd, 32'h3);
        apb(0, 8'h20, 0);
        chk({rd[30:0], err}, 32'h1);
        ctrl = 7'h01;
        mnt = 8'h05;
        ex = 3'h2;
        nat = 5'h1f;
        code = 32'h0001_0101;
        cfg();
        run(4096, 1);
        cmp(4096, 0);
        ctrl = 7'h00;
        cfg();
        run(4096, 0);
        cmp(4096, 0);
        ctrl = 7'h02;
        code = 32'h0003_5a96;
        cfg();
        run(4096, 0);
        cmp(4096, 0);
        crc_chk();
        for (int k = 0; k < 3; k++) begin
            ctrl = 7'h08;
            mnt = mt[k];
            cfg();
            run(4096, 0);
            cmp(4096, 0);
        end
        ctrl = 7'h06;
        cfg();
        run(4096, 0);
        cmp(4096, 0);
        ctrl = 7'h00;
        cfg();
        apb(1, `E1FG_OFS_FLAGEN, 32'h2);
        irq_low = 0;
        run(4096, 0);
        chk(irq_low, 1);
        apb(0, `E1FG_OFS_FLAG, 0);
        chk(rd[1], 1);
        apb(1, `E1FG_OFS_FLAGEN, 0);
        apb(1, `E1FG_OFS_FLAG, 32'h1f);
        chk(irq_n, 1);
        mnt = 8'h25;
        for (int k = 0; k < 5; k++) begin
            ctrl = (k == 3) ? 7'h02 : ((k == 4) ? 7'h08 : 7'h00);
            cfg();
            apb(1, `E1FG_OFS_INV, 32'h1 << k);
            run(8192, 0);
            cmp(8192, nbad[k]);
        end
        report_and_stop();
    end
endmodule : e1fg_tb

// ==== e1fg_top.sv ====
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "e1fg_map.svh"
// ==========================================================
// E1 transmit frame generator
module e1fg_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Payload in from payload control
    input  wire logic        in_valid,
    input  wire logic        in_bit,
    // Receive path status
    input  wire logic        rx_frame_lost,
    input  wire logic        rx_alt_alarm,
    input  wire logic        crc_mf_alignment_lost,
    input  wire logic        rx_crc_error,
    input  wire logic        rx_crc_smf,
    // Stream out to HDLC insertion
    output logic             out_valid,
    output logic             out_bit,
    // Interrupt
    output logic             irq_n
);
    // ======================================================
    // Register state
    logic [6:0]                ctrl_q;
    logic [7:0]                maint_q;
    logic [4:0]                naten_q;
    logic [19:0]               code_q;
    logic [2:0]                extra_q;
    e1fg_pkg::e1fg_flagvec_t   flag_q, flagen_q;
    e1fg_pkg::e1fg_invvec_t    pend_q, act_q;
    logic [1:0]                epend_q;
    logic [3:0]                crc_tx_q;
    logic [2:0]                b_q;
    logic [4:0]                ts_q;
    logic [3:0]                fr_q;
    logic [31:0]               prdata_q;
    logic                      pready_q, pslverr_q, out_valid_q, out_bit_q, irq_n_q;

    // ======================================================
    // Mode decode
    wire framing_disable              = ctrl_q[`E1FG_CTRL_FRAMING_DISABLE];
    wire crc_multiframe_enable        = ctrl_q[`E1FG_CTRL_CRC];
    wire modified_crc_select          = ctrl_q[`E1FG_CTRL_MOD];
    wire signalling_multiframe_enable = ctrl_q[`E1FG_CTRL_SIG];
    wire intl_bit_insert_disable      = ctrl_q[`E1FG_CTRL_INTL_BIT_INSERT_DISABLE];
    wire far_end_error_disable        = ctrl_q[`E1FG_CTRL_FEDIS];
    wire extra_bits_disable           = ctrl_q[`E1FG_CTRL_EXTRA_BITS_DISABLE];
    wire [1:0] intl_val               = maint_q[1:0];
    wire remote_alarm_manual          = maint_q[`E1FG_MNT_RAIM];
    wire remote_alarm_auto            = maint_q[`E1FG_MNT_RAIA];
    wire remote_alarm_criterion_select = maint_q[`E1FG_MNT_CRIT];
    wire sig_multiframe_alarm         = maint_q[`E1FG_MNT_MFAL];
    wire slot16_all_zero              = maint_q[`E1FG_MNT_ZERO];
    wire slot16_all_one               = maint_q[`E1FG_MNT_ONE];

    // Frame type selection
    wire frm_on   = ~framing_disable;
    wire mod_on   = frm_on & crc_multiframe_enable & modified_crc_select;
    wire crc_on   = frm_on & crc_multiframe_enable & ~modified_crc_select;
    wire basic_on = frm_on & ~mod_on;
    wire cas_on   = basic_on & signalling_multiframe_enable;
    wire crc_any  = crc_on | mod_on;

    // ======================================================
    // Position in the multiframe
    wire ts0    = (ts_q == 5'h00);
    wire ts16   = (ts_q == 5'h10);
    wire evenf  = ~fr_q[0];
    wire bit1   = (b_q == 3'h0);
    wire fstart = in_valid & ts0 & bit1;
    wire mfst   = fstart & (fr_q == 4'h0);
    wire smfst  = fstart & (fr_q[2:0] == 3'h0);
    wire smfend = in_valid & (ts_q == 5'h1f) & (b_q == 3'h7) & (fr_q[2:0] == 3'h7);
    wire [2:0] sa_idx = b_q - 3'h3;

    // ======================================================
    // TS0 bit 1 handling
    wire crc_pos  = ts0 & bit1 & evenf & crc_any;
    wire mfas_pos = ts0 & bit1 & ~evenf & crc_on & (fr_q < 4'hd);
    wire e_pos    = ts0 & bit1 & ~evenf & crc_on & (fr_q >= 4'hd);
    wire e_slot   = fr_q[1];                 // 0 for first E bit, 1 for second
    wire crc_val  = crc_tx_q[2'h3 - fr_q[2:1]] ^ act_q[e1fg_pkg::E1FG_INV_CRC];
    wire [5:0] mfas_val = `E1FG_MFAS_WORD >> (3'h5 - fr_q[3:1]);
    wire mfas_bit = mfas_val[0] ^ act_q[e1fg_pkg::E1FG_INV_MFAS];
    wire e_report = ~far_end_error_disable & ~crc_mf_alignment_lost;
    wire e_intl   = (~far_end_error_disable & crc_mf_alignment_lost)
                  | (far_end_error_disable & ~intl_bit_insert_disable);
    wire e_val    = e_report ? ~epend_q[e_slot] : intl_val[~e_slot];
    wire si_pos   = ts0 & bit1 & basic_on & ~crc_on & ~intl_bit_insert_disable;
    wire si_val   = evenf ? intl_val[1] : intl_val[0];

    // ======================================================
    // TS0 bits 2 to 8
    wire fas_pos   = ts0 & ~bit1 & evenf & basic_on;
    wire [6:0] fas_sh = `E1FG_FAS_WORD >> (3'h7 - b_q);
    wire fas_val   = fas_sh[0] ^ act_q[e1fg_pkg::E1FG_INV_FAS_WORD]
                   ^ (act_q[e1fg_pkg::E1FG_INV_FAS_BIT] & (b_q == 3'h1));
    wire nfas_pos  = ts0 & ~evenf & basic_on & (b_q == 3'h1);
    wire nfas_val  = 1'b1 ^ act_q[e1fg_pkg::E1FG_INV_NFAS];
    wire rai_pos   = ts0 & ~evenf & basic_on & (b_q == 3'h2);
    wire rai_cond  = remote_alarm_criterion_select ? rx_alt_alarm : rx_frame_lost;
    wire rai_val   = remote_alarm_manual | (remote_alarm_auto & rai_cond);
    wire sa_pos    = ts0 & ~evenf & frm_on & (b_q >= 3'h3) & naten_q[sa_idx];
    wire [1:0] cw_j = crc_any ? fr_q[2:1] : 2'h0;
    wire sa_val    = code_q[{sa_idx, cw_j}];

    // ======================================================
    // TS16 signalling multiframe
    wire sig_pos  = ts16 & cas_on;
    wire x_en     = ~extra_bits_disable;
    wire sig_val  = slot16_all_zero ? 1'b0 :
                    slot16_all_one  ? 1'b1 :
                    (fr_q != 4'h0)  ? in_bit :
                    (b_q < 3'h4)    ? act_q[e1fg_pkg::E1FG_INV_SIG] :
                    (b_q == 3'h5)   ? sig_multiframe_alarm :
                    ~x_en           ? in_bit :
                    (b_q == 3'h4)   ? extra_q[0] :
                    (b_q == 3'h6)   ? extra_q[1] : extra_q[2];

    // ======================================================
    // Output selection, lowest priority is pass-through
    wire out_d = framing_disable ? in_bit :
                 crc_pos  ? crc_val  :
                 mfas_pos ? mfas_bit :
                 (e_pos & (e_report | e_intl)) ? e_val :
                 si_pos   ? si_val   :
                 fas_pos  ? fas_val  :
                 nfas_pos ? nfas_val :
                 rai_pos  ? rai_val  :
                 sa_pos   ? sa_val   :
                 sig_pos  ? sig_val  : in_bit;

    // CRC runs over the sent stream with its own slots zero
    wire [3:0] crc_next;
    e1fg_crc #(.WIDTH(4), .POLY(`E1FG_CRC_POLY)) u_crc (
        .pclk     (pclk),
        .presetn  (presetn),
        .step     (in_valid),
        .restart  (smfend),
        .din      (out_d & ~crc_pos),
        .crc_next (crc_next)
    );

    // ======================================================
    // Request arming: a request is held until its unit starts
    wire even_st = fstart & evenf & basic_on;
    e1fg_pkg::e1fg_invvec_t arm;
    assign arm = {smfst & crc_any, mfst & cas_on, mfst & crc_on,
                  fstart & ~evenf & basic_on, even_st, even_st};
    wire apb_wr   = psel & penable & pwrite & pready_q;
    wire [7:0] ofs = paddr;
    wire wr_inv   = apb_wr & (ofs == `E1FG_OFS_INV);
    wire wr_flag  = apb_wr & (ofs == `E1FG_OFS_FLAG);
    e1fg_pkg::e1fg_invvec_t pend_d, act_d, wset;
    assign wset   = wr_inv ? pwdata[5:0] : 6'h00;
    assign pend_d = (pend_q & ~arm) | wset;
    assign act_d  = (act_q & ~arm) | (pend_q & arm);

    // E bit pending errors: a new error beats the clear
    wire [1:0] e_clr = {2{in_valid & e_pos & e_report}} & {e_slot, ~e_slot};
    wire [1:0] e_set = {2{rx_crc_error}} & {rx_crc_smf, ~rx_crc_smf};
    wire [1:0] epend_d = (epend_q & ~e_clr) | e_set;

    // Indication flags, set wins over write-one-to-clear
    e1fg_pkg::e1fg_flagvec_t fset, flag_d;
    assign fset   = {mfst & cas_on, smfst & crc_any, mfst & crc_any,
                     fstart & frm_on, even_st};
    assign flag_d = (flag_q & ~(wr_flag ? pwdata[4:0] : 5'h00)) | fset;

    // ======================================================
    // APB decode and read mux
    wire setup = psel & ~penable;
    wire hit   = (ofs[7:5] == 3'h0) & (ofs[1:0] == 2'h0);
    wire [31:0] rd_mux =
        (ofs == `E1FG_OFS_CTRL)   ? {25'h0, ctrl_q}   :
        (ofs == `E1FG_OFS_INV)    ? {26'h0, pend_q}   :
        (ofs == `E1FG_OFS_MAINT)  ? {24'h0, maint_q}  :
        (ofs == `E1FG_OFS_NATEN)  ? {27'h0, naten_q}  :
        (ofs == `E1FG_OFS_CODE)   ? {12'h0, code_q}   :
        (ofs == `E1FG_OFS_EXTRA)  ? {29'h0, extra_q}  :
        (ofs == `E1FG_OFS_FLAG)   ? {27'h0, flag_q}   :
        (ofs == `E1FG_OFS_FLAGEN) ? {27'h0, flagen_q} : 32'h0;

    // Zero-wait slave: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            prdata_q  <= (setup & ~pwrite & hit) ? rd_mux : 32'h0;
        end
    end

    // Software-owned configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= `E1FG_CTRL_RST;
            maint_q  <= `E1FG_MAINT_RST;
            naten_q  <= 5'h00;
            code_q   <= 20'h0;
            extra_q  <= 3'h7;
            flagen_q <= 5'h00;
        end else if (apb_wr) begin
            if (ofs == `E1FG_OFS_CTRL)   ctrl_q   <= pwdata[6:0];
            if (ofs == `E1FG_OFS_MAINT)  maint_q  <= pwdata[7:0];
            if (ofs == `E1FG_OFS_NATEN)  naten_q  <= pwdata[4:0];
            if (ofs == `E1FG_OFS_CODE)   code_q   <= pwdata[19:0];
            if (ofs == `E1FG_OFS_EXTRA)  extra_q  <= pwdata[2:0];
            if (ofs == `E1FG_OFS_FLAGEN) flagen_q <= pwdata[4:0];
        end
    end

    // Hardware-owned state: requests, errors, flags, CRC result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q   <= 6'h00;
            act_q    <= 6'h00;
            epend_q  <= 2'h0;
            flag_q   <= 5'h00;
            crc_tx_q <= 4'h0;
            irq_n_q  <= 1'b1;
        end else begin
            pend_q   <= pend_d;
            act_q    <= act_d;
            epend_q  <= epend_d;
            flag_q   <= flag_d;
            irq_n_q  <= ~|(flag_d & flagen_q);
            if (smfend) begin
                crc_tx_q <= crc_next;
            end
        end
    end

    // Bit, timeslot and frame counters advance per payload bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_q  <= 3'h0;
            ts_q <= 5'h00;
            fr_q <= 4'h0;
        end else if (in_valid) begin
            b_q <= b_q + 3'h1;
            if (b_q == 3'h7) begin
                ts_q <= ts_q + 5'h01;
                if (ts_q == 5'h1f) begin
                    fr_q <= fr_q + 4'h1;
                end
            end
        end
    end

    // One cycle of latency on the stream
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_q <= 1'b0;
            out_bit_q   <= 1'b0;
        end else begin
            out_valid_q <= in_valid;
            out_bit_q   <= in_valid ? out_d : 1'b0;
        end
    end

    // ======================================================
    // Outputs straight from flops
    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign out_valid = out_valid_q;
    assign out_bit   = out_bit_q;
    assign irq_n     = irq_n_q;
endmodule : e1fg_top
